// File: logic/tx_symbol_source_scrambler.sv
// Transmit symbol source selector, scrambler, symbol mapper and DAC
// level scaling. Assumes symbol_tick_i pulses once per symbol period
// and meter_tick_i pulses at each meter timer countdown expiry.
//
// How it works
// - Three-bit source field in the mode register selects source and scrambling.
// - Code 000 sends one pulse at selected level, surrounded by zeros.
// - Pulse repeats at meter timer interval; software keeps timer continuous.
// - Code 001 scrambles receiver detector sign and magnitude, four-level.
// - Code 010 sends channel unit bit pairs unscrambled, four-level.
// - Code 011 scrambles constant ones, four-level.
// - Code 101 scrambles channel unit bit pairs, four-level.
// - Code 110 zeroes magnitude, sends unscrambled sign as plus or minus three.
// - Code 111 scrambles ones once per symbol for sign, magnitude zero.
// - Four-level map: 00 -3, 01 -1, 11 +1, 10 +3.
// - Two-level: sign zero gives -3, sign one gives +3.
// - Scrambler is a 23-stage linear feedback shift register.
// - Taps 23 and 5 for local unit, 23 and 18 for remote.
// - Scrambler steps once per symbol in code 111, twice in scrambled four-level codes.
// - Transmitter off forces zero output in every mode.
// - Zero output only in pulse mode, reserved code 100 or transmitter off.
// - Each non-zero symbol becomes one of four DAC levels +3, +1, -1, -3.
// - DAC amplitude scales by the transmit level register.
// - Read-only trim value offsets process variation.
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ns
module tx_symbol_source_scrambler
#(
   parameter int DATA_W  = 8,
   parameter int ADDR_W  = 8,
   parameter int LEVEL_W = 8
)
(
   input  wire logic                            ref_clk_i,
   input  wire logic                            reset_i,
   input  wire logic [ADDR_W-1:0]               addr_i,
   input  wire logic [DATA_W-1:0]               wdata_i,
   input  wire logic                            wr_i,
   input  wire logic                            rd_i,
   output logic      [DATA_W-1:0]               rdata_o,
   input  wire logic                            symbol_tick_i,
   input  wire logic                            meter_tick_i,
   input  wire tx_source_pkg::bit_pair_t        chan_pair_i,
   input  wire tx_source_pkg::bit_pair_t        detect_pair_i,
   input  wire logic [LEVEL_W-1:0]              trim_value_i,
   output tx_source_pkg::tx_symbol_t            symbol_o,
   output logic signed [LEVEL_W+2:0]            dac_out_o
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // One scrambler step: returns {scrambled bit, next state}
   function automatic logic [23:0] lfsr_step
   (
      input logic [22:0] state,
      input logic        remote,
      input logic        din
   );
      logic tap;
      logic sbit;
      tap  = remote ? state[tx_source_pkg::TAP_REMOTE-1]
                    : state[tx_source_pkg::TAP_LOCAL-1];
      sbit = din ^ tap ^ state[tx_source_pkg::LFSR_LEN-1];
      return {sbit, state[21:0], sbit};
   endfunction : lfsr_step

   // Sign and magnitude to signed level
   function automatic logic signed [2:0] map_level
   (
      input tx_source_pkg::bit_pair_t p
   );
      logic signed [2:0] lv;
      case ({p.sign, p.mag})
         2'h0:
         begin
            lv = -3'sd3;
         end
         2'h1:
         begin
            lv = -3'sd1;
         end
         2'h3:
         begin
            lv = 3'sd1;
         end
         default:
         begin
            lv = 3'sd3;
         end
      endcase
      return lv;
   endfunction : map_level

   // Write strobe aimed at one register address
   function automatic logic reg_write
   (
      input logic              wr,
      input logic [ADDR_W-1:0] addr,
      input logic [ADDR_W-1:0] target
   );
      return wr && (addr == target);
   endfunction : reg_write

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]                mode;
   logic [LEVEL_W-1:0]        tx_level;
   logic [22:0]               lfsr;
   logic                      pulse_pending;
   tx_source_pkg::tx_source_t src;
   logic                      remote;
   logic                      tx_off;
   tx_source_pkg::bit_pair_t  pulse_pair;

   assign src        = tx_source_pkg::tx_source_t'(
                          mode[tx_source_pkg::SRC_LSB +: 3]);
   assign remote     = mode[tx_source_pkg::REMOTE_BIT];
   assign tx_off     = mode[tx_source_pkg::TX_OFF_BIT];
   assign pulse_pair = tx_source_pkg::bit_pair_t'(
                          mode[tx_source_pkg::PULSE_LSB +: 2]);

   // Mode register; bit 7 is not implemented and stays zero
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         mode <= tx_source_pkg::MODE_RESET;
      end
      else if (reg_write(wr_i, addr_i, tx_source_pkg::MODE_ADDR))
      begin
         mode <= {1'b0, wdata_i[6:0]};
      end
   end

   // Transmit level; software loads it from the trim value
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         tx_level <= tx_source_pkg::LEVEL_RESET;
      end
      else if (reg_write(wr_i, addr_i, tx_source_pkg::LEVEL_ADDR))
      begin
         tx_level <= wdata_i[LEVEL_W-1:0];
      end
   end

   // ---------------------------------------------------------------
   // Register read port
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         rdata_o <= '0;
      end
      else if (rd_i)
      begin
         case (addr_i)
            tx_source_pkg::MODE_ADDR:
            begin
               rdata_o <= mode;
            end
            tx_source_pkg::STATUS_ADDR:
            begin
               rdata_o <= {3'h0, pulse_pending, symbol_o.zero,
                           symbol_o.level};
            end
            tx_source_pkg::TRIM_ADDR:
            begin
               rdata_o <= trim_value_i;
            end
            tx_source_pkg::LEVEL_ADDR:
            begin
               rdata_o <= tx_level;
            end
            default:
            begin
               rdata_o <= '0;
            end
         endcase
      end
      else
      begin
         rdata_o <= '0;
      end
   end

   // ---------------------------------------------------------------
   // Isolated pulse timing
   // ---------------------------------------------------------------
   // Meter expiry arms one pulse for the next symbol; a new expiry in
   // the same cycle as the pulse goes out keeps it armed
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         pulse_pending <= 1'b0;
      end
      else if (meter_tick_i)
      begin
         pulse_pending <= 1'b1;
      end
      else if (symbol_tick_i)
      begin
         pulse_pending <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Source selection and scrambling
   // ---------------------------------------------------------------
   // Self-synchronising form: the scrambled bit itself is shifted in,
   // so a far end can descramble without knowing the seed. The two
   // four-level steps are chained within one cycle so that both bits
   // of a symbol come from consecutive register states.
   logic                      scr_din;
   logic [23:0]               step1;
   logic [23:0]               step2;
   logic [23:0]               ones_step;
   logic [22:0]               next_lfsr;
   tx_source_pkg::bit_pair_t  data_pair;
   tx_source_pkg::tx_symbol_t next_symbol;

   // Scrambler input pair; ones fill every mode without data
   always_comb
   begin
      case (src)
         tx_source_pkg::SRC_LOOP_SCR:
         begin
            data_pair = detect_pair_i;
         end
         tx_source_pkg::SRC_DATA_SCR:
         begin
            data_pair = chan_pair_i;
         end
         default:
         begin
            data_pair = 2'h3;
         end
      endcase
   end

   // Two chained steps for four-level, one step for two-level ones
   assign scr_din   = 1'b1;
   assign step1     = lfsr_step(lfsr, remote, data_pair.sign);
   assign step2     = lfsr_step(step1[22:0], remote, data_pair.mag);
   assign ones_step = lfsr_step(lfsr, remote, scr_din);

   // Unscrambled, pulse and reserved modes hold the register still
   always_comb
   begin
      case (src)
         tx_source_pkg::SRC_LOOP_SCR,
         tx_source_pkg::SRC_ONES_4L,
         tx_source_pkg::SRC_DATA_SCR:
         begin
            next_lfsr = step2[22:0];
         end
         tx_source_pkg::SRC_ONES_2L:
         begin
            next_lfsr = ones_step[22:0];
         end
         default:
         begin
            next_lfsr = lfsr;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         lfsr <= tx_source_pkg::LFSR_RESET;
      end
      else if (symbol_tick_i)
      begin
         lfsr <= next_lfsr;
      end
   end

   // ---------------------------------------------------------------
   // Symbol mapping
   // ---------------------------------------------------------------
   // Zero appears only in pulse gaps, reserved code or while off
   always_comb
   begin
      next_symbol.zero  = 1'b0;
      next_symbol.level = 3'sd0;
      case (src)
         tx_source_pkg::SRC_PULSE:
         begin
            if (pulse_pending)
            begin
               next_symbol.level = map_level(pulse_pair);
            end
            else
            begin
               next_symbol.zero = 1'b1;
            end
         end
         tx_source_pkg::SRC_LOOP_SCR,
         tx_source_pkg::SRC_ONES_4L,
         tx_source_pkg::SRC_DATA_SCR:
         begin
            next_symbol.level =
               map_level({step1[23], step2[23]});
         end
         tx_source_pkg::SRC_DATA_4L:
         begin
            next_symbol.level = map_level(chan_pair_i);
         end
         tx_source_pkg::SRC_DATA_2L:
         begin
            next_symbol.level =
               map_level({chan_pair_i.sign, 1'b0});
         end
         tx_source_pkg::SRC_ONES_2L:
         begin
            next_symbol.level =
               map_level({ones_step[23], 1'b0});
         end
         default:
         begin
            next_symbol.zero = 1'b1;
         end
      endcase
      if (tx_off)
      begin
         next_symbol.zero  = 1'b1;
         next_symbol.level = 3'sd0;
      end
      if (next_symbol.zero)
      begin
         next_symbol.level = 3'sd0;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         symbol_o <= '{zero: 1'b1, level: 3'sd0};
      end
      else if (symbol_tick_i)
      begin
         symbol_o <= next_symbol;
      end
   end

   // ---------------------------------------------------------------
   // DAC level scaling
   // ---------------------------------------------------------------
   // Level times unsigned gain; the gain gets a zero sign bit so a
   // large setting is never read as negative
   logic signed [LEVEL_W+2:0] next_dac;
   assign next_dac = (LEVEL_W+3)'($signed(symbol_o.level)
                     * $signed({1'b0, tx_level}));

   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i)
      begin
         dac_out_o <= '0;
      end
      else
      begin
         dac_out_o <= next_dac;
      end
   end

endmodule : tx_symbol_source_scrambler

// File: logic/tx_source_pkg.sv
// Constants and types for the transmit symbol source and scrambler.
// Assumes a single clock domain and a byte-wide register port.
package tx_source_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] MODE_ADDR   = 8'h0b;
   localparam logic [7:0] STATUS_ADDR = 8'h0c;
   localparam logic [7:0] TRIM_ADDR   = 8'h28;
   localparam logic [7:0] LEVEL_ADDR  = 8'h29;

   // ---------------------------------------------------------------
   // Mode register fields
   // ---------------------------------------------------------------
   localparam int SRC_LSB     = 0;
   localparam int REMOTE_BIT  = 3;
   localparam int PULSE_LSB   = 4;
   localparam int TX_OFF_BIT  = 6;
   localparam logic [7:0] MODE_RESET  = 8'h42;
   localparam logic [7:0] LEVEL_RESET = 8'h80;

   // ---------------------------------------------------------------
   // Scrambler
   // ---------------------------------------------------------------
   localparam int LFSR_LEN        = 23;
   localparam int TAP_LOCAL       = 5;
   localparam int TAP_REMOTE      = 18;
   localparam logic [22:0] LFSR_RESET = 23'h000001;

   // ---------------------------------------------------------------
   // Source select codes
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      SRC_PULSE     = 3'h0,
      SRC_LOOP_SCR  = 3'h1,
      SRC_DATA_4L   = 3'h2,
      SRC_ONES_4L   = 3'h3,
      SRC_RESERVED  = 3'h4,
      SRC_DATA_SCR  = 3'h5,
      SRC_DATA_2L   = 3'h6,
      SRC_ONES_2L   = 3'h7
   } tx_source_t;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic sign;
      logic mag;
   } bit_pair_t;

   typedef struct packed {
      logic              zero;
      logic signed [2:0] level;
   } tx_symbol_t;

endpackage : tx_source_pkg

// File: testbench/tx_source_sva.sv
// Checker for the transmit symbol source, scrambler and DAC scaling.
// Assumes it is bound to the top module; shadows mode and level registers.
`timescale 1ns/1ns
module tx_source_sva
(
   input wire logic                      ref_clk_i,
   input wire logic                      reset_i,
   input wire logic [7:0]                addr_i,
   input wire logic [7:0]                wdata_i,
   input wire logic                      wr_i,
   input wire logic                      rd_i,
   input wire logic [7:0]                rdata_o,
   input wire logic                      symbol_tick_i,
   input wire tx_source_pkg::bit_pair_t  chan_pair_i,
   input wire logic [7:0]                trim_value_i,
   input wire tx_source_pkg::tx_symbol_t symbol_o,
   input wire logic signed [10:0]        dac_out_o
);
   logic [7:0] mode;
   logic [7:0] gain;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   // ---------------------------------------------------------------
   // Register shadows
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i) mode <= 8'h42;
      else if (wr_i && addr_i == 8'h0b) mode <= wdata_i & 8'h7f;
   end
   always_ff @(posedge ref_clk_i)
   begin
      if (reset_i) gain <= 8'h80;
      else if (wr_i && addr_i == 8'h29) gain <= wdata_i;
   end
   function automatic logic signed [2:0] map4(input logic s, input logic m);
      return s ? (m ? 3'sh1 : 3'sh3) : (m ? -3'sh1 : -3'sh3);
   endfunction : map4
   sequence s_live;
      symbol_tick_i && !mode[6];
   endsequence
   a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
      else $error("read data not zero outside read");
   a_mode_read: assert property (rd_i && addr_i == 8'h0b |=> rdata_o == $past(mode))
      else $error("mode readback wrong");
   a_trim_read: assert property (rd_i && addr_i == 8'h28 |=> rdata_o == $past(trim_value_i))
      else $error("trim readback wrong");
   a_tx_off: assert property (symbol_tick_i && mode[6] |=> symbol_o.zero)
      else $error("output not zero while off");
   a_no_zero: assert property (s_live ##0 (mode[2:0] != 3'h0 && mode[2:0] != 3'h4)
      |=> !symbol_o.zero)
      else $error("zero in data mode");
   a_map_four: assert property (s_live ##0 mode[2:0] == 3'h2
      |=> symbol_o.level == map4($past(chan_pair_i.sign), $past(chan_pair_i.mag)))
      else $error("four-level map wrong");
   a_two_level: assert property (s_live ##0 mode[2:0] == 3'h6
      |=> symbol_o.level == ($past(chan_pair_i.sign) ? 3'sh3 : -3'sh3))
      else $error("two-level data wrong");
   a_ones_two: assert property (s_live ##0 mode[2:0] == 3'h7
      |=> symbol_o.level == 3'sh3 || symbol_o.level == -3'sh3)
      else $error("two-level ones out of range");
   a_pulse_level: assert property (s_live ##0 mode[2:0] == 3'h0
      |=> symbol_o.zero || symbol_o.level == map4($past(mode[5]), $past(mode[4])))
      else $error("pulse level wrong");
   a_dac_scale: assert property (dac_out_o
      == $past(symbol_o.level) * $signed({1'b0, $past(gain)}))
      else $error("dac output not scaled");
endmodule : tx_source_sva
bind tx_symbol_source_scrambler tx_source_sva chk (.ref_clk_i, .reset_i, .addr_i, .wdata_i,
   .wr_i, .rd_i, .rdata_o, .symbol_tick_i, .chan_pair_i, .trim_value_i, .symbol_o, .dac_out_o);

// File: testbench/far_end_line.sv
// Far-end line model: a fresh detector decision each symbol.
// Assumes the bench pulses symbol_tick_i once per symbol.
`timescale 1ns/1ns
module far_end_line
(
   input  wire logic                 ref_clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 symbol_tick_i,
   output tx_source_pkg::bit_pair_t  detect_pair_o
);
   always @(posedge ref_clk_i)
   begin
      if (reset_i) detect_pair_o <= 2'h0;
      else if (symbol_tick_i) detect_pair_o <= 2'($urandom);
   end
endmodule : far_end_line

// File: testbench/tb_tx_symbol_source_scrambler.sv
// Self-checking bench for the transmit symbol source and scrambler.
// Assumes the register port, tick inputs and reset values of the design.
`timescale 1ns/1ns
module tb_tx_symbol_source_scrambler;
   logic                      ref_clk_i, reset_i, wr_i, rd_i, symbol_tick_i, meter_tick_i;
   logic [7:0]                addr_i, wdata_i, rdata_o, trim_value_i, mode, g;
   tx_source_pkg::bit_pair_t  chan_pair_i, detect_pair_i;
   tx_source_pkg::tx_symbol_t symbol_o;
   logic signed [10:0]        dac_out_o;
   logic [22:0]               lfsr;
   int                        n_mismatch, compares, gain, srcs[6];
   bit                        armed;
   tx_symbol_source_scrambler uut (.ref_clk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i,
      .rdata_o, .symbol_tick_i, .meter_tick_i, .chan_pair_i, .detect_pair_i, .trim_value_i,
      .symbol_o, .dac_out_o);
   far_end_line far (.ref_clk_i, .reset_i, .symbol_tick_i, .detect_pair_o(detect_pair_i));
   initial
   begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // ---------------------------------------------------------------
   // Model and bus tasks
   // ---------------------------------------------------------------
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge ref_clk_i);
      wr_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge ref_clk_i);
      rd_i <= 1'b0;
      #1 chk("rdata", rdata_o, exp);
   endtask : rd
   function automatic logic step(input logic din);
      logic o;
      o = din ^ lfsr[mode[3] ? 17 : 4] ^ lfsr[22];
      lfsr = {lfsr[21:0], o};
      return o;
   endfunction : step
   function automatic int map4(input logic s, input logic m);
      return s ? (m ? 1 : 3) : (m ? -1 : -3);
   endfunction : map4
   task automatic tick();
      tx_source_pkg::bit_pair_t c, d, p;
      int lv;
      bit z;
      c = 2'($urandom);
      d = detect_pair_i;
      z = 1'b0;
      lv = 0;
      @(posedge ref_clk_i);
      symbol_tick_i <= 1'b1;
      chan_pair_i <= c;
      p = mode[2] ? c : d;
      case (mode[2:0])
         3'h0: begin z = !armed; lv = armed ? map4(mode[5], mode[4]) : 0; armed = 0; end
         3'h2: lv = map4(c.sign, c.mag);
         3'h4: z = 1'b1;
         3'h6: lv = c.sign ? 3 : -3;
         3'h7: lv = step(1'b1) ? 3 : -3;
         default: begin p.sign = step(mode[1] | p.sign); p.mag = step(mode[1] | p.mag);
            lv = map4(p.sign, p.mag); end
      endcase
      if (mode[6]) begin z = 1'b1; lv = 0; end
      @(posedge ref_clk_i);
      symbol_tick_i <= 1'b0;
      #1 chk("symbol", symbol_o, {z, 3'(lv)});
      @(posedge ref_clk_i);
      #1 chk("dac", dac_out_o, 16'(lv * gain));
   endtask : tick
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {reset_i, wr_i, rd_i, symbol_tick_i, meter_tick_i} = 5'h10;
      {addr_i, wdata_i, chan_pair_i} = 18'h0;
      void'($urandom(73));
      trim_value_i = 8'($urandom);
      srcs = '{2, 6, 1, 5, 3, 7};
      {mode, gain, lfsr, armed} = {8'h42, 32'h80, 23'h1, 1'b0};
      repeat (5) @(posedge ref_clk_i);
      reset_i <= 1'b0;
      rd(8'h0b, 8'h42);
      rd(8'h29, 8'h80);
      rd(8'h55, 8'h00);
      wr(8'h28, ~trim_value_i);
      rd(8'h28, trim_value_i);
      tick();
      wr(8'h29, trim_value_i);
      gain = trim_value_i;
      for (int r = 0; r < 2; r++)
      begin
         foreach (srcs[i])
         begin
            g = 8'($urandom);
            wr(8'h29, g);
            gain = g;
            mode = {4'h0, r[0], 3'(srcs[i])};
            wr(8'h0b, mode);
            rd(8'h0b, mode);
            repeat (8) tick();
         end
      end
      for (int p = 0; p < 4; p++)
      begin
         mode = {2'h0, 2'(p), 4'h0};
         wr(8'h0b, mode);
         tick();
         @(posedge ref_clk_i);
         meter_tick_i <= 1'b1;
         armed = 1'b1;
         @(posedge ref_clk_i);
         meter_tick_i <= 1'b0;
         repeat (2) tick();
      end
      mode = 8'h04;
      wr(8'h0b, mode);
      tick();
      mode = 8'h42;
      wr(8'h0b, 8'hc2);
      rd(8'h0b, mode);
      tick();
      final_report();
   end
   initial
   begin
      #200000;
      n_mismatch++;
      final_report();
   end
endmodule : tb_tx_symbol_source_scrambler
